// *** verilog/cfil_top.sv ***
/*
 * Codec fault interrupt logic: sticky fault flags, masks, interrupt pin.
 * Assumes a parallel register port decoded from the control port, with
 * one-cycle read and write strobes, and event inputs synchronous to the
 * core clock. A read of a flag register returns and clears it, and in
 * mode 0 also masks what it returned.
 * The reserved pin drive code releases the pin. An event that lands in
 * the cycle of a clearing read keeps its flag. Writes to the flag
 * registers, to reserved bits and to unmapped offsets are ignored;
 * unmapped reads return zero. Configuration seen in the first cycle
 * after reset is taken as the baseline, not as a fault.
 */
// How it works
// - Mode 0: reading set flag sets mask
// - Mode 1: reading flags leaves masks alone
// - Pin drive: high, low, low open-drain
// - Test-mode entry write raises test-mode fault
// - Format, speed, master change while powered: port fault
// - Slave ratio change raises port and clock fault
// - Master ratio change raises no fault
// - Mask 0 passes event, 1 blocks it
// - Mask one: test, port, clock, ADC bits
// - Mask two: DAC clip bits 3..0
// - Flags one read only, mask layout, sticky
// - Port fault flag sticky until cleared
// - Clock fault flag sticky until cleared
// - ADC overflow flags sticky until cleared
// - Flags two: sticky DAC clip bits
`timescale 1ns/100ps
module cfil_top (
   input wire logic CORE_CLK_I,
   input wire logic SRST_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_WDATA_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic [cfil_pkg::CFIL_FMT_W-1:0] SERIAL_FORMAT_SELECT_I,
   input wire logic [cfil_pkg::CFIL_SPEED_W-1:0] SPEED_RANGE_I,
   input wire logic CLOCK_MASTER_SELECT_I,
   input wire logic [cfil_pkg::CFIL_RATIO_W-1:0] CLOCK_RATIO_I,
   input wire logic [cfil_pkg::CFIL_N_ADC-1:0] ADC_POWERDOWN_I,
   input wire logic [cfil_pkg::CFIL_N_DAC-1:0] DAC_POWERDOWN_I,
   input wire logic TESTMODE_ENTRY_I,
   input wire logic [cfil_pkg::CFIL_N_ADC-1:0] ADC_OVERFLOW_I,
   input wire logic [cfil_pkg::CFIL_N_DAC-1:0] DAC_CLIP_I,
   output logic IRQ_PIN_O,
   output logic IRQ_PIN_OE_O
);
   import cfil_pkg::*;

   // ==========================================================
   // Declarations
   cfil_cfg_if cfg ();

   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [7:0] mask_one_r;
   logic [7:0] mask_one_nxt;
   logic [7:0] mask_two_r;
   logic [7:0] mask_two_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic irq_pin_r;
   logic irq_pin_nxt;
   logic irq_oe_r;
   logic irq_oe_nxt;

   logic port_fault;
   logic clock_fault;
   logic [7:0] set_one;
   logic [CFIL_N_DAC-1:0] set_two;
   logic [7:0] flags_one;
   logic [CFIL_N_DAC-1:0] flags_two;
   logic [7:0] flags_two_word;
   logic rd_flags_one;
   logic rd_flags_two;
   logic auto_mask;
   logic irq_active;
   logic [7:0] pend_one;
   logic [7:0] pend_two;
   cfil_pol_e pol;

   // ==========================================================
   // Configuration to the fault detector
   assign cfg.serial_format_select = SERIAL_FORMAT_SELECT_I;
   assign cfg.speed_range = SPEED_RANGE_I;
   assign cfg.clock_master_select = CLOCK_MASTER_SELECT_I;
   assign cfg.clock_ratio = CLOCK_RATIO_I;
   assign cfg.adc_powerdown = ADC_POWERDOWN_I;
   assign cfg.dac_powerdown = DAC_POWERDOWN_I;

   cfil_fault_det u_det (
      .clk_i(CORE_CLK_I),
      .srst_i(SRST_I),
      .cfg(cfg.det),
      .port_fault_o(port_fault),
      .clock_fault_o(clock_fault)
   );

   // ==========================================================
   // Event gathering
   always_comb begin
      set_one = CFIL_ZERO;
      set_one[CFIL_TESTMODE_BIT] = TESTMODE_ENTRY_I;
      set_one[CFIL_PORT_FMT_BIT] = port_fault;
      set_one[CFIL_CLOCKING_BIT] = clock_fault;
      set_one[CFIL_ADC_LO_BIT +: CFIL_N_ADC] = ADC_OVERFLOW_I;
      set_two = DAC_CLIP_I;
   end

   // ==========================================================
   // Read strobes
   always_comb begin
      rd_flags_one = REG_RD_I & (REG_ADDR_I == CFIL_OFS_IRQ_FLAGS_ONE);
      rd_flags_two = REG_RD_I & (REG_ADDR_I == CFIL_OFS_IRQ_FLAGS_TWO);
      auto_mask = ~ctrl_r[CFIL_CTRL_MODE_BIT];
   end

   // ==========================================================
   // Sticky flag banks
   cfil_sticky #(
      .W(CFIL_REG_W)
   ) u_flags_one (
      .clk_i(CORE_CLK_I),
      .srst_i(SRST_I),
      .set_i(set_one),
      .clr_i(rd_flags_one),
      .flags_o(flags_one)
   );

   cfil_sticky #(
      .W(CFIL_N_DAC)
   ) u_flags_two (
      .clk_i(CORE_CLK_I),
      .srst_i(SRST_I),
      .set_i(set_two),
      .clr_i(rd_flags_two),
      .flags_o(flags_two)
   );

   always_comb begin
      flags_two_word = CFIL_ZERO;
      flags_two_word[CFIL_DAC_LO_BIT +: CFIL_N_DAC] = flags_two;
   end

   // ==========================================================
   // Control and mask registers
   always_comb begin
      ctrl_nxt = ctrl_r;
      mask_one_nxt = mask_one_r;
      mask_two_nxt = mask_two_r;
      if (REG_WR_I) begin
         case (REG_ADDR_I)
            CFIL_OFS_IRQ_CONTROL: begin
               ctrl_nxt = REG_WDATA_I & CFIL_CTRL_USED;
            end
            CFIL_OFS_IRQ_MASK_ONE: begin
               mask_one_nxt = REG_WDATA_I & CFIL_MASK_ONE_USED;
            end
            CFIL_OFS_IRQ_MASK_TWO: begin
               mask_two_nxt = REG_WDATA_I & CFIL_MASK_TWO_USED;
            end
            default: begin
               ctrl_nxt = ctrl_r;
            end
         endcase
      end
      // Flags seen by the host mask themselves in mode 0
      if (rd_flags_one && auto_mask) begin
         mask_one_nxt = mask_one_nxt | (flags_one & CFIL_MASK_ONE_USED);
      end
      if (rd_flags_two && auto_mask) begin
         mask_two_nxt = mask_two_nxt | flags_two_word;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         ctrl_r <= CFIL_CTRL_RST;
         mask_one_r <= CFIL_MASK_ONE_RST;
         mask_two_r <= CFIL_MASK_TWO_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
         mask_one_r <= mask_one_nxt;
         mask_two_r <= mask_two_nxt;
      end
   end

   // ==========================================================
   // Read data
   always_comb begin
      rdata_nxt = rdata_r;
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            CFIL_OFS_IRQ_CONTROL: begin
               rdata_nxt = ctrl_r;
            end
            CFIL_OFS_IRQ_MASK_ONE: begin
               rdata_nxt = mask_one_r;
            end
            CFIL_OFS_IRQ_MASK_TWO: begin
               rdata_nxt = mask_two_r;
            end
            CFIL_OFS_IRQ_FLAGS_ONE: begin
               rdata_nxt = flags_one;
            end
            CFIL_OFS_IRQ_FLAGS_TWO: begin
               rdata_nxt = flags_two_word;
            end
            default: begin
               rdata_nxt = CFIL_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         rdata_r <= CFIL_ZERO;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // Per-bit interrupt sources
   for (genvar i = 0; i < CFIL_REG_W; i++) begin : g_src
      always_comb begin
         // A set flag counts only while its mask bit is 0
         pend_one[i] = flags_one[i] & ~mask_one_r[i] & CFIL_MASK_ONE_USED[i];
         pend_two[i] = flags_two_word[i] & ~mask_two_r[i] & CFIL_MASK_TWO_USED[i];
      end
   end

   // ==========================================================
   // Interrupt pin
   always_comb begin
      irq_active = (|pend_one) | (|pend_two);
      pol = cfil_pol_e'(ctrl_r[CFIL_CTRL_POL_HI:CFIL_CTRL_POL_LO]);
      case (pol)
         CFIL_POL_HIGH: begin
            irq_pin_nxt = irq_active;
            irq_oe_nxt = 1'b1;
         end
         CFIL_POL_LOW: begin
            irq_pin_nxt = ~irq_active;
            irq_oe_nxt = 1'b1;
         end
         CFIL_POL_LOW_OD: begin
            irq_pin_nxt = 1'b0;
            irq_oe_nxt = irq_active;
         end
         default: begin
            irq_pin_nxt = 1'b0;
            irq_oe_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         irq_pin_r <= 1'b0;
         irq_oe_r <= 1'b1;
      end else begin
         irq_pin_r <= irq_pin_nxt;
         irq_oe_r <= irq_oe_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign REG_RDATA_O = rdata_r;
   assign IRQ_PIN_O = irq_pin_r;
   assign IRQ_PIN_OE_O = irq_oe_r;
endmodule

// *** verilog/cfil_pkg.sv ***
/*
 * Constants and types for the codec fault interrupt logic.
 * Assumes an 8-bit register port with 8-bit addresses.
 */
package cfil_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] CFIL_OFS_IRQ_CONTROL = 8'h1e;
   localparam logic [7:0] CFIL_OFS_IRQ_MASK_ONE = 8'h1f;
   localparam logic [7:0] CFIL_OFS_IRQ_MASK_TWO = 8'h20;
   localparam logic [7:0] CFIL_OFS_IRQ_FLAGS_ONE = 8'h21;
   localparam logic [7:0] CFIL_OFS_IRQ_FLAGS_TWO = 8'h22;

   // ==========================================================
   // Field positions
   localparam int CFIL_CTRL_MODE_BIT = 7;
   localparam int CFIL_CTRL_POL_HI = 6;
   localparam int CFIL_CTRL_POL_LO = 5;
   localparam int CFIL_TESTMODE_BIT = 7;
   localparam int CFIL_PORT_FMT_BIT = 6;
   localparam int CFIL_CLOCKING_BIT = 5;
   localparam int CFIL_ADC_LO_BIT = 0;
   localparam int CFIL_DAC_LO_BIT = 0;

   // ==========================================================
   // Widths
   localparam int CFIL_REG_W = 8;
   localparam int CFIL_N_ADC = 4;
   localparam int CFIL_N_DAC = 4;
   localparam int CFIL_FMT_W = 2;
   localparam int CFIL_SPEED_W = 2;
   localparam int CFIL_RATIO_W = 3;

   // ==========================================================
   // Reset values and writable bits
   localparam logic [7:0] CFIL_CTRL_RST = 8'h00;
   localparam logic [7:0] CFIL_MASK_ONE_RST = 8'h00;
   localparam logic [7:0] CFIL_MASK_TWO_RST = 8'h00;
   localparam logic [7:0] CFIL_CTRL_USED = 8'he0;
   localparam logic [7:0] CFIL_MASK_ONE_USED = 8'hef;
   localparam logic [7:0] CFIL_MASK_TWO_USED = 8'h0f;
   localparam logic [7:0] CFIL_ZERO = 8'h00;

   // ==========================================================
   // Interrupt pin drive modes
   typedef enum logic [1:0] {
      CFIL_POL_HIGH = 2'b00,
      CFIL_POL_LOW = 2'b01,
      CFIL_POL_LOW_OD = 2'b10,
      CFIL_POL_RSVD = 2'b11
   } cfil_pol_e;

endpackage

// *** verilog/cfil_cfg_if.sv ***
/*
 * Carries the serial port and clocking configuration to the fault detector.
 * Assumes one clock domain; the top drives, the detector samples.
 */
`timescale 1ns/100ps
interface cfil_cfg_if;
   import cfil_pkg::*;

   logic [CFIL_FMT_W-1:0] serial_format_select;
   logic [CFIL_SPEED_W-1:0] speed_range;
   logic clock_master_select;
   logic [CFIL_RATIO_W-1:0] clock_ratio;
   logic [CFIL_N_ADC-1:0] adc_powerdown;
   logic [CFIL_N_DAC-1:0] dac_powerdown;

   modport src (
      output serial_format_select, speed_range, clock_master_select,
      output clock_ratio, adc_powerdown, dac_powerdown
   );
   modport det (
      input serial_format_select, speed_range, clock_master_select,
      input clock_ratio, adc_powerdown, dac_powerdown
   );
endinterface

// *** verilog/cfil_sticky.sv ***
/*
 * Bank of sticky flags: set by events, cleared by a clear strobe.
 * Assumes set and clear are synchronous to clk_i; set wins.
 */
`timescale 1ns/100ps
module cfil_sticky #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [W-1:0] set_i,
   input wire logic clr_i,
   output logic [W-1:0] flags_o
);
   import cfil_pkg::*;

   logic [W-1:0] flags_r;
   logic [W-1:0] flags_nxt;

   // ==========================================================
   // Per-bit next value
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_comb begin
         flags_nxt[i] = set_i[i] | (flags_r[i] & ~clr_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         flags_r <= '0;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign flags_o = flags_r;
endmodule

// *** verilog/cfil_fault_det.sv ***
/*
 * Spots configuration changes made while the converters are powered up.
 * Assumes configuration inputs are synchronous to clk_i.
 */
`timescale 1ns/100ps
module cfil_fault_det (
   input wire logic clk_i,
   input wire logic srst_i,
   cfil_cfg_if.det cfg,
   output logic port_fault_o,
   output logic clock_fault_o
);
   import cfil_pkg::*;

   localparam int CFG_W = CFIL_FMT_W + CFIL_SPEED_W + 1;

   logic [CFG_W-1:0] cfg_now;
   logic [CFG_W-1:0] cfg_r;
   logic [CFG_W-1:0] cfg_nxt;
   logic [CFIL_RATIO_W-1:0] ratio_r;
   logic [CFIL_RATIO_W-1:0] ratio_nxt;
   logic seen_r;
   logic seen_nxt;
   logic live;
   logic ratio_move;

   // ==========================================================
   // Change detection
   always_comb begin
      cfg_now = {cfg.serial_format_select, cfg.speed_range, cfg.clock_master_select};
      cfg_nxt = cfg_now;
      ratio_nxt = cfg.clock_ratio;
      seen_nxt = 1'b1;
      live = ~(&{cfg.adc_powerdown, cfg.dac_powerdown});
      // Ratio only moves the slave; a master follows its own clock
      ratio_move = seen_r & ~cfg.clock_master_select & (ratio_r != cfg.clock_ratio);
      port_fault_o = live & ((seen_r & (cfg_r != cfg_now)) | ratio_move);
      clock_fault_o = live & ratio_move;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cfg_r <= '0;
         ratio_r <= '0;
         seen_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         ratio_r <= ratio_nxt;
         seen_r <= seen_nxt;
      end
   end
endmodule

// *** sim/cfil_top_props.sv ***
/* Checker for the codec fault interrupt logic.
   Assumes it is bound to cfil_top and sees only the top ports. */
`timescale 1ns/100ps
module cfil_top_props (
   input wire logic CORE_CLK_I,
   input wire logic SRST_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic [7:0] REG_RDATA_O,
   input wire logic [cfil_pkg::CFIL_FMT_W-1:0] SERIAL_FORMAT_SELECT_I,
   input wire logic [cfil_pkg::CFIL_SPEED_W-1:0] SPEED_RANGE_I,
   input wire logic CLOCK_MASTER_SELECT_I,
   input wire logic [cfil_pkg::CFIL_RATIO_W-1:0] CLOCK_RATIO_I,
   input wire logic [cfil_pkg::CFIL_N_ADC-1:0] ADC_POWERDOWN_I,
   input wire logic [cfil_pkg::CFIL_N_DAC-1:0] DAC_POWERDOWN_I,
   input wire logic TESTMODE_ENTRY_I,
   input wire logic [cfil_pkg::CFIL_N_ADC-1:0] ADC_OVERFLOW_I,
   input wire logic [cfil_pkg::CFIL_N_DAC-1:0] DAC_CLIP_I,
   input wire logic IRQ_PIN_O,
   input wire logic IRQ_PIN_OE_O
);
   import cfil_pkg::*;
   logic [1:0] pol_r, pol_nxt, pol_d_r;
   logic rd1, rd2;
   assign rd1 = REG_RD_I && REG_ADDR_I == CFIL_OFS_IRQ_FLAGS_ONE;
   assign rd2 = REG_RD_I && REG_ADDR_I == CFIL_OFS_IRQ_FLAGS_TWO;
   // ==========================================
   // Shadow of the pin drive field
   always_comb begin
      pol_nxt = pol_r;
      if (REG_WR_I && REG_ADDR_I == CFIL_OFS_IRQ_CONTROL) begin
         pol_nxt = REG_WDATA_I[6:5];
      end
   end
   always_ff @(posedge CORE_CLK_I) begin
      pol_r <= SRST_I ? 2'b00 : pol_nxt;
      pol_d_r <= SRST_I ? 2'b00 : pol_r;
   end
   // ==========================================
   // Properties
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (SRST_I);
   sequence s_wr_rd(logic [7:0] a);
      REG_WR_I && !REG_RD_I && REG_ADDR_I == a ##1 !REG_WR_I
         ##1 REG_RD_I && !REG_WR_I && REG_ADDR_I == a;
   endsequence
   sequence s_two_reads;
      rd1 && ADC_OVERFLOW_I == 4'h0 && !TESTMODE_ENTRY_I ##1 rd1;
   endsequence
   AST_ADC_STICKY: assert property (rd1 && !$past(SRST_I) && $past(ADC_OVERFLOW_I[0])
      |=> REG_RDATA_O[0]) else $error("adc flag not latched");
   AST_TEST_STICKY: assert property (rd1 && !$past(SRST_I) && $past(TESTMODE_ENTRY_I)
      |=> REG_RDATA_O[7]) else $error("test flag not latched");
   AST_DAC_STICKY: assert property (rd2 && !$past(SRST_I) && $past(DAC_CLIP_I[0])
      |=> REG_RDATA_O[0]) else $error("clip flag not latched");
   AST_READ_CLEARS: assert property (s_two_reads |=> REG_RDATA_O[7] == 1'b0
      && REG_RDATA_O[3:0] == 4'h0) else $error("flags not cleared");
   AST_MASK_ONE_RB: assert property (s_wr_rd(CFIL_OFS_IRQ_MASK_ONE)
      |=> REG_RDATA_O == ($past(REG_WDATA_I, 3) & 8'hef)) else $error("mask one");
   AST_MASK_TWO_RB: assert property (s_wr_rd(CFIL_OFS_IRQ_MASK_TWO)
      |=> REG_RDATA_O == ($past(REG_WDATA_I, 3) & 8'h0f)) else $error("mask two");
   AST_POL_HIGH: assert property (pol_r == 2'b00 && pol_d_r == 2'b00 |-> IRQ_PIN_OE_O)
      else $error("high mode not driven");
   AST_POL_LOW: assert property (pol_r == 2'b01 && pol_d_r == 2'b01 |-> IRQ_PIN_OE_O)
      else $error("low mode not driven");
   AST_POL_OD: assert property (pol_r == 2'b10 && pol_d_r == 2'b10 |-> !IRQ_PIN_O)
      else $error("open drain drives high");
   AST_POL_RSVD: assert property (pol_r == 2'b11 && pol_d_r == 2'b11 |-> !IRQ_PIN_OE_O)
      else $error("reserved mode drives");
endmodule
bind cfil_top cfil_top_props u_props (.CORE_CLK_I, .SRST_I, .REG_ADDR_I, .REG_WR_I,
   .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .SERIAL_FORMAT_SELECT_I, .SPEED_RANGE_I,
   .CLOCK_MASTER_SELECT_I, .CLOCK_RATIO_I, .ADC_POWERDOWN_I, .DAC_POWERDOWN_I,
   .TESTMODE_ENTRY_I, .ADC_OVERFLOW_I, .DAC_CLIP_I, .IRQ_PIN_O, .IRQ_PIN_OE_O);

// *** sim/cfil_irq_host.sv ***
/* Host side of the interrupt line.
   Assumes a board pull-up on the line. */
`timescale 1ns/100ps
module cfil_irq_host (
   input wire logic pin_i,
   input wire logic oe_i,
   output logic irq_wire_o
);
   // ==========================================
   // Pull-up holds the line high when released
   assign irq_wire_o = oe_i ? pin_i : 1'b1;
endmodule

// *** sim/tb_codec_fault_interrupt_logic.sv ***
/* Self-checking bench for the codec fault interrupt logic.
   Assumes the checker is bound and the host model resolves the pin. */
`timescale 1ns/100ps
module tb_codec_fault_interrupt_logic;
   import cfil_pkg::*;
   logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, tst = 1'b0, mst = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
   logic [1:0] fmt = 2'h0, spd = 2'h0;
   logic [2:0] ratio = 3'h0;
   logic [3:0] apd = 4'h0, dpd = 4'h0, aov = 4'h0, dcl = 4'h0;
   logic pin, oe, irq;
   int error_cnt = 0, check_count = 0, cyc = 0;
   cfil_top dut (.CORE_CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WR_I(wr),
      .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
      .SERIAL_FORMAT_SELECT_I(fmt), .SPEED_RANGE_I(spd), .CLOCK_MASTER_SELECT_I(mst),
      .CLOCK_RATIO_I(ratio), .ADC_POWERDOWN_I(apd), .DAC_POWERDOWN_I(dpd),
      .TESTMODE_ENTRY_I(tst), .ADC_OVERFLOW_I(aov), .DAC_CLIP_I(dcl),
      .IRQ_PIN_O(pin), .IRQ_PIN_OE_O(oe));
   cfil_irq_host host (.pin_i(pin), .oe_i(oe), .irq_wire_o(irq));
   initial begin
      forever #4 clk = ~clk;
   end
   // ==========================================
   // Tasks
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         give_verdict;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      addr = a;
      wdata = v;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      addr = a;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
      d = rdata;
   endtask
   task automatic cfg(input logic [1:0] f, s, input logic m, input logic [2:0] r,
      input logic [7:0] e);
      fmt = f;
      spd = s;
      mst = m;
      ratio = r;
      tick(2);
      rd_reg(CFIL_OFS_IRQ_FLAGS_ONE);
      chk(d, e, "config fault");
   endtask
   task automatic pulse_adc(input logic [3:0] v);
      aov = v;
      tick(1);
      aov = 4'h0;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      tick(8);
      srst = 1'b0;
      tick(2);
      for (int a = 8'h1d; a <= 8'h23; a++) begin
         rd_reg(8'(a));
         chk(d, 8'h00, "reset value");
      end
      wr_reg(CFIL_OFS_IRQ_CONTROL, 8'hff);
      rd_reg(CFIL_OFS_IRQ_CONTROL);
      chk(d, 8'he0, "control");
      wr_reg(CFIL_OFS_IRQ_CONTROL, 8'h00);
      wr_reg(CFIL_OFS_IRQ_MASK_ONE, 8'hff);
      rd_reg(CFIL_OFS_IRQ_MASK_ONE);
      chk(d, 8'hef, "mask one");
      wr_reg(CFIL_OFS_IRQ_MASK_TWO, 8'hff);
      rd_reg(CFIL_OFS_IRQ_MASK_TWO);
      chk(d, 8'h0f, "mask two");
      wr_reg(CFIL_OFS_IRQ_MASK_ONE, 8'h00);
      wr_reg(CFIL_OFS_IRQ_MASK_TWO, 8'h00);
      chk({6'h00, pin, oe}, 8'h01, "idle pin");
      pulse_adc(4'h5);
      tick(2);
      chk({7'h00, pin}, 8'h01, "pin active");
      rd_reg(CFIL_OFS_IRQ_FLAGS_ONE);
      chk(d, 8'h05, "adc flags");
      rd_reg(CFIL_OFS_IRQ_MASK_ONE);
      chk(d, 8'h05, "auto mask");
      chk({7'h00, pin}, 8'h00, "pin cleared");
      pulse_adc(4'h1);
      tick(2);
      chk({7'h00, pin}, 8'h00, "pin masked");
      rd_reg(CFIL_OFS_IRQ_FLAGS_ONE);
      chk(d, 8'h01, "masked flag");
      pulse_adc(4'h9);
      rd_reg(CFIL_OFS_IRQ_FLAGS_ONE);
      chk(d, 8'h09, "adc1 and adc4 flags");
      tst = 1'b1;
      tick(1);
      tst = 1'b0;
      rd_reg(CFIL_OFS_IRQ_FLAGS_ONE);
      chk(d, 8'h80, "test flag");
      pulse_adc(4'h4);
      rd = 1'b1;
      tick(2);
      rd = 1'b0;
      tick(1);
      chk(rdata, 8'h00, "cleared flags");
      wr_reg(CFIL_OFS_IRQ_CONTROL, 8'h80);
      dcl = 4'h9;
      tick(1);
      dcl = 4'h0;
      rd_reg(CFIL_OFS_IRQ_FLAGS_TWO);
      chk(d, 8'h09, "clip flags");
      rd_reg(CFIL_OFS_IRQ_MASK_TWO);
      chk(d, 8'h00, "no auto mask");
      cfg(2'h1, 2'h0, 1'b0, 3'h0, 8'h40);
      cfg(2'h1, 2'h2, 1'b0, 3'h0, 8'h40);
      cfg(2'h1, 2'h2, 1'b0, 3'h3, 8'h60);
      cfg(2'h1, 2'h2, 1'b1, 3'h3, 8'h40);
      cfg(2'h1, 2'h2, 1'b1, 3'h5, 8'h00);
      apd = 4'hf;
      dpd = 4'hf;
      cfg(2'h2, 2'h2, 1'b0, 3'h5, 8'h00);
      dpd = 4'h7;
      cfg(2'h3, 2'h2, 1'b0, 3'h5, 8'h40);
      wr_reg(CFIL_OFS_IRQ_CONTROL, 8'ha0);
      chk({6'h00, pin, oe}, 8'h03, "low idle");
      pulse_adc(4'h2);
      tick(2);
      chk({7'h00, pin}, 8'h00, "low active");
      wr_reg(CFIL_OFS_IRQ_CONTROL, 8'hc0);
      chk({6'h00, irq, oe}, 8'h01, "open drain active");
      rd_reg(CFIL_OFS_IRQ_FLAGS_ONE);
      tick(1);
      chk({6'h00, irq, oe}, 8'h02, "open drain idle");
      give_verdict;
   end
endmodule
